// ==== tsp_host_master.sv ====
`timescale 1ns/1ps
`include "tsp_regs.svh"
module tsp_host_master
  import tsp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  tsp_link_if.host link,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // -----------------------------------------------------------------
  // host state
  // -----------------------------------------------------------------
  tsp_host_state_type st_reg, st_next;
  logic [15:0] div_reg, div_next;
  logic [4:0] bit_reg, bit_next;
  logic sel_reg, sel_next, sck_reg, sck_next, sdi_reg, sdi_next;
  logic [15:0] tx_reg, tx_next, rx_reg, rx_next;
  logic [9:0] temp_reg, temp_next;
  logic sd_reg, sd_next;
  logic [2:0] so_sync_reg, so_sync_next;
  logic so_reg, so_next;
  logic aw_reg, aw_next, w_reg, w_next;
  logic [3:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic awr_reg, awr_next, wr_reg, wr_next, bv_reg, bv_next;
  logic arr_reg, arr_next, rv_reg, rv_next;
  logic [31:0] rd_reg, rd_next;
  logic go;

  always_comb begin
    so_sync_next = {so_sync_reg[1:0], link.serial_out};
    so_next = (so_sync_reg[2] == so_sync_reg[1]) ? so_sync_reg[1] : so_reg;
  end

  // -----------------------------------------------------------------
  // axi4-lite slave
  // -----------------------------------------------------------------
  always_comb begin
    aw_next = aw_reg;
    awa_next = awa_reg;
    w_next = w_reg;
    wd_next = wd_reg;
    awr_next = !aw_reg && !bv_reg && !(s_axi_awvalid && awr_reg);
    wr_next = !w_reg && !bv_reg && !(s_axi_wvalid && wr_reg);
    bv_next = bv_reg;
    go = 1'b0;
    sd_next = sd_reg;
    if (s_axi_awvalid && awr_reg) begin
      aw_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_reg) begin
      w_next = 1'b1;
      wd_next = s_axi_wdata;
    end
    if (aw_reg && w_reg && !bv_reg) begin
      bv_next = 1'b1;
      aw_next = 1'b0;
      w_next = 1'b0;
      if (awa_reg == `TSP_ADDR_CTRL) begin
        sd_next = wd_reg[`TSP_CTRL_SD];
        go = wd_reg[`TSP_CTRL_GO];
      end
    end
    if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    arr_next = !rv_reg && !(s_axi_arvalid && arr_reg);
    rv_next = rv_reg;
    rd_next = rd_reg;
    if (s_axi_arvalid && arr_reg) begin
      rv_next = 1'b1;
      case (s_axi_araddr)
        `TSP_ADDR_CTRL: rd_next = {30'h0, sd_reg, 1'b0};
        `TSP_ADDR_STAT: rd_next = {31'h0, st_reg != TSP_IDLE};
        `TSP_ADDR_TEMP: rd_next = {{22{temp_reg[9]}}, temp_reg};
        default: rd_next = 32'h0;
      endcase
    end
    if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // serial frame engine
  // -----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    div_next = div_reg;
    bit_next = bit_reg;
    sel_next = sel_reg;
    sck_next = sck_reg;
    sdi_next = sdi_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    temp_next = temp_reg;
    case (st_reg)
      TSP_IDLE: begin
        sel_next = 1'b0;
        sck_next = 1'b0;
        if (go) begin
          st_next = TSP_SHIFT;
          sel_next = 1'b1;
          div_next = 16'h0;
          bit_next = 5'h0;
          tx_next = {2'b00, sd_next, 13'h0};
          sdi_next = 1'b0;
        end
      end
      TSP_SHIFT: begin
        div_next = 16'(div_reg + 16'h1);
        if (div_reg == `TSP_SCLK_HALF) begin
          div_next = 16'h0;
          sck_next = !sck_reg;
          if (!sck_reg) begin
            sdi_next = tx_reg[15]; // presented before the falling edge
            tx_next = {tx_reg[14:0], 1'b0};
          end else begin
            rx_next = {rx_reg[14:0], so_reg};
            bit_next = 5'(bit_reg + 5'h1);
            if (5'(bit_reg + 5'h1) == `TSP_FRAME_LEN) begin
              st_next = TSP_DONE;
            end
          end
        end
      end
      TSP_DONE: begin
        div_next = 16'(div_reg + 16'h1);
        if (div_reg == `TSP_SCLK_HALF) begin
          // output reaches so_reg one bit late
          temp_next = rx_reg[13:4];
          sel_next = 1'b0;
          sdi_next = 1'b0;
          st_next = TSP_IDLE;
        end
      end
      default: st_next = TSP_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= TSP_IDLE;
      div_reg <= 16'h0;
      bit_reg <= 5'h0;
      sel_reg <= 1'b0;
      sck_reg <= 1'b0;
      sdi_reg <= 1'b0;
      tx_reg <= 16'h0;
      rx_reg <= 16'h0;
      temp_reg <= 10'h0;
      sd_reg <= 1'b0;
      so_sync_reg <= 3'h0;
      so_reg <= 1'b0;
      aw_reg <= 1'b0;
      awa_reg <= 4'h0;
      w_reg <= 1'b0;
      wd_reg <= 32'h0;
      awr_reg <= 1'b0;
      wr_reg <= 1'b0;
      bv_reg <= 1'b0;
      arr_reg <= 1'b0;
      rv_reg <= 1'b0;
      rd_reg <= 32'h0;
    end else begin
      st_reg <= st_next;
      div_reg <= div_next;
      bit_reg <= bit_next;
      sel_reg <= sel_next;
      sck_reg <= sck_next;
      sdi_reg <= sdi_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      temp_reg <= temp_next;
      sd_reg <= sd_next;
      so_sync_reg <= so_sync_next;
      so_reg <= so_next;
      aw_reg <= aw_next;
      awa_reg <= awa_next;
      w_reg <= w_next;
      wd_reg <= wd_next;
      awr_reg <= awr_next;
      wr_reg <= wr_next;
      bv_reg <= bv_next;
      arr_reg <= arr_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
    end
  end

  assign link.select = sel_reg;
  assign link.sclk = sck_reg;
  assign link.serial_in = sdi_reg;
  assign s_axi_awready = awr_reg;
  assign s_axi_wready = wr_reg;
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = arr_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = 2'h0;
endmodule

// ==== tsp_link_if.sv ====
`timescale 1ns/1ps
interface tsp_link_if;
  logic select;
  logic sclk;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe_n;
  modport dev(input select, input sclk, input serial_in, output serial_out, output serial_out_oe_n);
  modport host(output select, output sclk, output serial_in, input serial_out, input serial_out_oe_n);
endinterface

// ==== tsp_link_props.sv ====
`timescale 1ns/1ps
module tsp_link_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic select,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  // ----
  // sclk edge count and age
  // ----
  logic sclk_reg, sclk_next;
  logic [4:0] rise_reg, rise_next;
  logic [3:0] age_reg, age_next;
  always_comb begin
    sclk_next = sclk;
    rise_next = select ? rise_reg : 5'h00;
    age_next = (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;
    if (sclk && !sclk_reg) begin
      age_next = 4'h0;
      if (select) begin
        rise_next = rise_reg + 5'h01;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_reg <= 1'b0;
      rise_reg <= 5'h00;
      age_reg <= 4'hf;
    end else begin
      sclk_reg <= sclk_next;
      rise_reg <= rise_next;
      age_reg <= age_next;
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_frame_len;
    $fell(select) |-> rise_reg == 5'h10;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not 16 clocks");
  property p_idle_clk;
    !select |-> !sclk;
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("sclk high outside frame");
  property p_clk_high;
    $rose(sclk) |-> sclk [*5] ##1 !sclk;
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("sclk high phase wrong");
  property p_drive;
    $rose(select) |-> ##[1:30] !serial_out_oe_n;
  endproperty
  a_drive: assert property (p_drive) else $error("serial_out not driven");
  property p_keep;
    select && !serial_out_oe_n |=> !serial_out_oe_n;
  endproperty
  a_keep: assert property (p_keep) else $error("serial_out released early");
  property p_release;
    $fell(select) |-> ##[1:6] serial_out_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("serial_out not released");
  property p_idle_hiz;
    !select [*8] |-> serial_out_oe_n;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("serial_out driven while idle");
  property p_out_edge;
    select && !serial_out_oe_n && !$past(serial_out_oe_n) && $changed(serial_out) |-> age_reg inside {[1:5]};
  endproperty
  a_out_edge: assert property (p_out_edge) else $error("serial_out changed off rising edge");
  c_frame: cover property ($fell(select) && rise_reg == 5'h10);
  c_drive: cover property ($fell(serial_out_oe_n));
  c_one: cover property (select && serial_out);
  c_pd: cover property (select && serial_in);
endmodule

// ==== tsp_pkg.sv ====
package tsp_pkg;
  typedef enum logic [2:0] {
    TSP_IDLE = 3'b001,
    TSP_SHIFT = 3'b010,
    TSP_DONE = 3'b100
  } tsp_host_state_type;
  typedef enum logic [1:0] {
    TSP_RUN_IDLE = 2'b01,
    TSP_RUN_CONV = 2'b10
  } tsp_conv_state_type;
endpackage

// ==== tsp_regs.svh ====
`ifndef TSP_REGS_SVH
`define TSP_REGS_SVH
// -----------------------------------------------------------------
// frame layout
// -----------------------------------------------------------------
`define TSP_FRAME_LEN 5'd16
`define TSP_LOAD_EDGE 5'd15
`define TSP_PD_BIT 4'hd
`define TSP_TEMP_W 10
`define TSP_CTRL_W 16
// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define TSP_CLK_NS 10
`define TSP_UPDATE_US 400
`define TSP_CONV_US 25
`define TSP_UPDATE_CYC ((`TSP_UPDATE_US * 1000) / `TSP_CLK_NS)
`define TSP_CONV_CYC ((`TSP_CONV_US * 1000) / `TSP_CLK_NS)
`define TSP_SCLK_HALF 16'h0004
// -----------------------------------------------------------------
// host register map
// -----------------------------------------------------------------
`define TSP_ADDR_CTRL 4'h0
`define TSP_ADDR_STAT 4'h4
`define TSP_ADDR_TEMP 4'h8
`define TSP_CTRL_GO 0
`define TSP_CTRL_SD 1
`define TSP_STAT_BUSY 0
`endif

// ==== tsp_sensor_port.sv ====
`timescale 1ns/1ps
`include "tsp_regs.svh"
// What this block does
// - read-only 10-bit two's-complement temperature register
// - code is temperature times four
// - works with serial_in held low
// - host holds select low before first access
// - sclk edges ignored while select low
// - host returns select low between frames
// - device slave only; host drives sclk
// - out from temperature, in to control
// - sample in on fall, drive out on rise
// - 16-clock frame: zero then ten bits
// - hold last bit until select falls, then release
// - control written in same frame as read
// - third input bit requests shutdown
// - host sends zero except power-down bit
// - control loads on fifteenth rising edge
// - early select fall discards shifted input
// - conversion every 400 us in normal mode
// - shutdown stops conversions, keeps result
// - restart conversion after access or wake
// - read before completion returns previous result
module tsp_sensor_port
  import tsp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  tsp_link_if.dev link,
  input wire logic [9:0] adc_sample,
  output logic shutdown,
  output logic [9:0] temperature_value,
  output logic conv_busy
);
  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [2:0] sel_sync_reg, sel_sync_next;
  logic [2:0] clk_sync_reg, clk_sync_next;
  logic [2:0] din_sync_reg, din_sync_next;
  logic sel_reg, sel_next, sck_reg, sck_next, din_reg, din_next;
  // -----------------------------------------------------------------
  // frame state
  // -----------------------------------------------------------------
  logic [4:0] rise_cnt_reg, rise_cnt_next;
  logic [15:0] in_sh_reg, in_sh_next;
  logic [10:0] out_sh_reg, out_sh_next;
  logic sdo_reg, sdo_next, oe_n_reg, oe_n_next;
  logic [15:0] power_control_reg, power_control_next;
  logic [9:0] temp_reg, temp_next;
  logic restart;
  // -----------------------------------------------------------------
  // conversion timer
  // -----------------------------------------------------------------
  tsp_conv_state_type conv_reg, conv_next;
  logic [15:0] tmr_reg, tmr_next;
  logic rise, fall;

  always_comb begin
    sel_sync_next = {sel_sync_reg[1:0], link.select};
    clk_sync_next = {clk_sync_reg[1:0], link.sclk};
    din_sync_next = {din_sync_reg[1:0], link.serial_in};
    sel_next = (sel_sync_reg[2] == sel_sync_reg[1]) ? sel_sync_reg[1] : sel_reg;
    sck_next = (clk_sync_reg[2] == clk_sync_reg[1]) ? clk_sync_reg[1] : sck_reg;
    din_next = (din_sync_reg[2] == din_sync_reg[1]) ? din_sync_reg[1] : din_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_sync_reg <= 3'h0;
      clk_sync_reg <= 3'h0;
      din_sync_reg <= 3'h0;
      sel_reg <= 1'b0;
      sck_reg <= 1'b0;
      din_reg <= 1'b0;
    end else begin
      sel_sync_reg <= sel_sync_next;
      clk_sync_reg <= clk_sync_next;
      din_sync_reg <= din_sync_next;
      sel_reg <= sel_next;
      sck_reg <= sck_next;
      din_reg <= din_next;
    end
  end

  // -----------------------------------------------------------------
  // edge detect
  // -----------------------------------------------------------------
  assign rise = sel_reg && sel_next && !sck_reg && sck_next;
  assign fall = sel_reg && sel_next && sck_reg && !sck_next;

  // -----------------------------------------------------------------
  // frame shifter
  // -----------------------------------------------------------------
  always_comb begin
    rise_cnt_next = rise_cnt_reg;
    in_sh_next = in_sh_reg;
    out_sh_next = out_sh_reg;
    sdo_next = sdo_reg;
    oe_n_next = oe_n_reg;
    power_control_next = power_control_reg;
    restart = 1'b0;
    if (!sel_reg) begin
      // idle: reload for the next frame, drop partial input
      rise_cnt_next = 5'h0;
      in_sh_next = 16'h0;
      out_sh_next = {1'b0, temp_reg};
      oe_n_next = 1'b1;
      sdo_next = 1'b0;
    end else begin
      if (!sel_next) begin
        restart = 1'b1;
      end
      if (rise) begin
        oe_n_next = 1'b0;
        sdo_next = out_sh_reg[10];
        out_sh_next = {out_sh_reg[9:0], out_sh_reg[0]};
        if (rise_cnt_reg != `TSP_FRAME_LEN) begin
          rise_cnt_next = 5'(rise_cnt_reg + 5'h1);
        end
        if (5'(rise_cnt_reg + 5'h1) == `TSP_LOAD_EDGE) begin
          power_control_next = in_sh_reg;
        end
      end
      if (fall) begin
        in_sh_next = {in_sh_reg[14:0], din_reg};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_cnt_reg <= 5'h0;
      in_sh_reg <= 16'h0;
      out_sh_reg <= 11'h0;
      sdo_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      power_control_reg <= 16'h0;
    end else begin
      rise_cnt_reg <= rise_cnt_next;
      in_sh_reg <= in_sh_next;
      out_sh_reg <= out_sh_next;
      sdo_reg <= sdo_next;
      oe_n_reg <= oe_n_next;
      power_control_reg <= power_control_next;
    end
  end

  // -----------------------------------------------------------------
  // power-down decode
  // -----------------------------------------------------------------
  // 14 bits shifted at the fifteenth rise: bit 11 is the third
  wire sd_now = power_control_reg[`TSP_PD_BIT - 4'h2];

  // -----------------------------------------------------------------
  // conversion sequencer
  // -----------------------------------------------------------------
  always_comb begin
    conv_next = conv_reg;
    tmr_next = tmr_reg;
    temp_next = temp_reg;
    if (restart || (power_control_reg != power_control_next)) begin
      conv_next = TSP_RUN_CONV;
      tmr_next = 16'h0;
    end else if (sd_now) begin
      conv_next = TSP_RUN_IDLE;
      tmr_next = 16'h0;
    end else begin
      tmr_next = 16'(tmr_reg + 16'h1);
      case (conv_reg)
        TSP_RUN_IDLE: begin
          if (tmr_reg >= 16'(`TSP_UPDATE_CYC - `TSP_CONV_CYC - 1)) begin
            conv_next = TSP_RUN_CONV;
            tmr_next = 16'h0;
          end
        end
        TSP_RUN_CONV: begin
          if (tmr_reg >= 16'(`TSP_CONV_CYC - 1)) begin
            temp_next = adc_sample;
            conv_next = TSP_RUN_IDLE;
            tmr_next = 16'h0;
          end
        end
        default: conv_next = TSP_RUN_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_reg <= TSP_RUN_CONV;
      tmr_reg <= 16'h0;
      temp_reg <= 10'h0;
      shutdown <= 1'b0;
      temperature_value <= 10'h0;
      conv_busy <= 1'b0;
    end else begin
      conv_reg <= conv_next;
      tmr_reg <= tmr_next;
      temp_reg <= temp_next;
      shutdown <= sd_now;
      temperature_value <= temp_reg;
      conv_busy <= (conv_reg == TSP_RUN_CONV) && !sd_now;
    end
  end

  // -----------------------------------------------------------------
  // pin drivers
  // -----------------------------------------------------------------
  assign link.serial_out = sdo_reg;
  assign link.serial_out_oe_n = oe_n_reg;
endmodule

// ==== tsp_sensor_port_tb_top.sv ====
`timescale 1ns/1ps
`include "tsp_regs.svh"
module tsp_sensor_port_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, sd1, sd2, cb1;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp;
  logic [9:0] adc, tv1;
  logic [15:0] rw;
  logic [9:0] codes [5] = '{10'h200, 10'h3ff, 10'h000, 10'h1fc, 10'h064};
  int n_errors = 0;
  int n_tests = 0;
  tsp_link_if l1();
  tsp_link_if l2();
  tsp_sensor_port i_tsp_sensor_port(.aclk(aclk), .aresetn(aresetn), .link(l1.dev), .adc_sample(adc),
    .shutdown(sd1), .temperature_value(tv1), .conv_busy(cb1));
  tsp_sensor_port i_tsp_sensor_port_2(.aclk(aclk), .aresetn(aresetn), .link(l2.dev), .adc_sample(adc),
    .shutdown(sd2), .temperature_value(), .conv_busy());
  tsp_host_master i_tsp_host_master(.aclk(aclk), .aresetn(aresetn), .link(l1.host), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  tsp_link_props i_tsp_link_props(.aclk(aclk), .aresetn(aresetn), .select(l1.select), .sclk(l1.sclk),
    .serial_in(l1.serial_in), .serial_out(l1.serial_out), .serial_out_oe_n(l1.serial_out_oe_n));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ----
  // checks and bus tasks
  // ----
  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input logic bad);
    if (bad) begin
      n_errors++;
      $display("FAIL %0t wait limit reached", $time);
      final_report();
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
    end while (!bvalid && n < 100);
    tmo(n >= 100);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b0;
    end while (!rvalid && n < 100);
    d = rdata;
    tmo(n >= 100);
  endtask
  task automatic run_frame(input logic sd);
    logic [31:0] s;
    int n;
    n = 0;
    axi_wr(`TSP_ADDR_CTRL, {30'h0, sd, 1'b1});
    do begin
      axi_rd(`TSP_ADDR_STAT, s);
      n++;
    end while (s[0] !== 1'b1 && n < 20);
    tmo(n >= 20);
    do begin
      axi_rd(`TSP_ADDR_STAT, s);
      n++;
    end while (s[0] !== 1'b0 && n < 500);
    tmo(n >= 500);
  endtask
  task automatic bang(input int n, input logic [15:0] w, output logic [15:0] r);
    r = 16'h0000;
    @(posedge aclk);
    l2.select <= 1'b1;
    repeat (4) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      l2.sclk <= 1'b1;
      l2.serial_in <= w[15-i];
      repeat (4) @(posedge aclk);
      l2.sclk <= 1'b0;
      repeat (4) @(posedge aclk);
      r[15-i] = l2.serial_out;
    end
    l2.serial_in <= 1'b0;
    l2.select <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {l2.select, l2.sclk, l2.serial_in} = 3'b000;
    adc = codes[0];
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3000) @(posedge aclk);
    foreach (codes[i]) begin
      adc <= codes[i];
      run_frame(1'b0);
      repeat (2600) @(posedge aclk);
      run_frame(1'b0);
      axi_rd(`TSP_ADDR_TEMP, rd);
      chk(rd, {{22{codes[i][9]}}, codes[i]});
      chk(tv1, codes[i]);
    end
    axi_wr(`TSP_ADDR_TEMP, 32'h0000_0155);
    axi_rd(`TSP_ADDR_TEMP, rd);
    chk(rd, 32'h0000_0064);
    axi_rd(4'hc, rd);
    chk(rd, 32'h0000_0000);
    bang(16, 16'h0000, rw);
    chk(rw, {1'b0, codes[0], 5'h00});
    adc <= 10'h1fc;
    run_frame(1'b0);
    axi_rd(`TSP_ADDR_TEMP, rd);
    chk(rd, 32'h0000_0064);
    repeat (2600) @(posedge aclk);
    run_frame(1'b1);
    chk(sd1, 1'b1);
    chk(cb1, 1'b0);
    adc <= 10'h3ff;
    repeat (3000) @(posedge aclk);
    run_frame(1'b1);
    axi_rd(`TSP_ADDR_TEMP, rd);
    chk(rd, 32'h0000_01fc);
    run_frame(1'b0);
    chk(sd1, 1'b0);
    repeat (10) @(posedge aclk);
    chk(cb1, 1'b1);
    repeat (2600) @(posedge aclk);
    run_frame(1'b0);
    axi_rd(`TSP_ADDR_TEMP, rd);
    chk(rd, 32'hffff_ffff);
    bang(10, 16'h2000, rw);
    chk(sd2, 1'b0);
    repeat (2600) @(posedge aclk);
    bang(16, 16'h2000, rw);
    chk(sd2, 1'b1);
    chk(rw, {1'b0, 10'h3ff, 5'h1f});
    bang(16, 16'h0000, rw);
    chk(sd2, 1'b0);
    final_report();
  end
endmodule
